// [scd_pkg.sv]
// constants and types shared by the serial command decoder files
// assumes a single 125 MHz clock domain; pins are synchronised before use
package scd_pkg;

  // clocking: fast system clock oversamples the serial clock
  localparam int CLK_MHZ      = 125;
  localparam int SCLK_MAX_MHZ = 25;
  localparam int SYNC_STAGES  = 2;

  // transaction lengths in serial bits
  localparam logic [4:0] LEN_8  = 5'h08;
  localparam logic [4:0] LEN_16 = 5'h10;
  localparam logic [4:0] LEN_24 = 5'h18;

  // reset and power-up values
  localparam logic [7:0]  SETUP_RST  = 8'h28;
  localparam logic [7:0]  ZERO_RST   = 8'h00;
  localparam logic [11:0] DAC_WAKE_HI = 12'hfff;
  localparam logic [11:0] DAC_WAKE_LO = 12'h000;
  localparam logic [1:0]  STRAP_LOAD = 2'h2;

  // setup register fields
  localparam int SET_CLK_HI = 5;
  localparam int SET_CLK_LO = 4;
  localparam int SET_POL_HI = 1;
  localparam int SET_POL_LO = 0;
  localparam logic [1:0] CLK_MODE_INT_CNV = 2'h0;
  localparam logic [1:0] CLK_MODE_EXT_CNV = 2'h1;
  localparam logic [1:0] CLK_MODE_EXT     = 2'h3;
  localparam logic [1:0] POL_UNIPOLAR     = 2'h2;
  localparam logic [1:0] POL_BIPOLAR      = 2'h3;

  // reset register fields
  localparam int RST_REQ_BIT = 2;

  // command codes for the low command group
  localparam logic [7:0] CMD_GPIO_CFG = 8'h03;
  localparam logic [7:0] CMD_GPIO_WR  = 8'h02;
  localparam logic [7:0] CMD_GPIO_RD  = 8'h01;

  // output word layout: leading zeros, 10-bit result, trailing sub-bits
  localparam int RES_BITS = 10;
  localparam int OUT_BITS = 16;
  localparam logic [3:0] OUT_LEAD = 4'h0;
  localparam logic [1:0] OUT_TAIL = 2'h0;

  typedef enum logic [1:0] {
    SCD_IDLE,
    SCD_RECV,
    SCD_IGNORE
  } scd_state_t;

endpackage

// [scd_sync.sv]
// two flip-flop synchroniser for a group of pin inputs
// assumes inputs are asynchronous to clk; RST_VAL is the idle level
`timescale 1ns/1ps
module scd_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  // first stage feeds only the second
  always_comb begin
    meta_next = d;
    q_next    = meta_reg;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end else begin
      meta_reg <= meta_next;
      q        <= q_next;
    end
  end

endmodule

// [scd_out_shift.sv]
// serial output shifter: parallel load, msb first shift
// assumes load and shift are single-cycle enables from the same clock
`timescale 1ns/1ps
module scd_out_shift #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_word,
  input  wire logic         shift,
  output logic              msb
);

  logic [W-1:0] word_reg;
  logic [W-1:0] word_next;

  // load wins over shift, zeros fill behind
  always_comb begin
    word_next = word_reg;
    if (load) begin
      word_next = load_word;
    end else if (shift) begin
      word_next = {word_reg[W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_reg <= '0;
    end else begin
      word_reg <= word_next;
    end
  end

  assign msb = word_reg[W-1];

endmodule

// [scd_serial_decoder.sv]
// serial slave port and command byte decoder for an adc/dac/gpio converter
// assumes serial pins come from an external master; op_done and result
// inputs come from converter logic on clk
`timescale 1ns/1ps
module scd_serial_decoder #(
  parameter bit HAS_GPIO = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        din,
  input  wire logic        convert_start_n,
  input  wire logic        dac_wake_select,
  input  wire logic        op_done,
  input  wire logic        result_signed,
  input  wire logic [9:0]  result_code,
  output logic             dout_reg,
  output logic             dout_oe_reg,
  output logic             eoc_n_reg,
  output logic             conv_start_reg,
  output logic             convert_start_n_is_start_reg,
  output logic [7:0]       conversion_request_reg,
  output logic             conv_strobe_reg,
  output logic [7:0]       converter_setup_reg,
  output logic [7:0]       unipolar_reg,
  output logic [7:0]       bipolar_reg,
  output logic [7:0]       averaging_control_reg,
  output logic [7:0]       reset_control_reg,
  output logic             reset_strobe_reg,
  output logic [7:0]       dac_select_reg,
  output logic [11:0]      dac_input_reg,
  output logic             dac_strobe_reg,
  output logic [7:0]       gpio_out_reg,
  output logic             gpio_cfg_strobe_reg,
  output logic             gpio_read_strobe_reg
);

  logic [4:0]              pins_s;
  logic                    sclk_s;
  logic                    cs_s;
  logic                    din_s;
  logic                    cnv_s;
  logic                    wake_s;
  logic                    sclk_d_reg;
  logic                    cs_d_reg;
  logic                    cnv_d_reg;
  logic                    sclk_fall;
  logic                    sclk_rise;
  logic                    cs_fall;
  logic                    cnv_fall;
  logic                    accept;
  logic                    cmd_done;
  logic [7:0]              cmd_byte;
  logic [4:0]              cnt_inc;
  logic [1:0]              clk_mode;
  logic                    out_msb;
  logic                    out_shift;
  logic [scd_pkg::RES_BITS-1:0] res_fmt;
  scd_pkg::scd_state_t     state_reg;
  scd_pkg::scd_state_t     state_next;
  logic [4:0]              bit_cnt_reg;
  logic [4:0]              bit_cnt_next;
  logic [4:0]              len_reg;
  logic [4:0]              len_next;
  logic [23:0]             shift_reg;
  logic [23:0]             shift_next;
  logic [7:0]              cmd_reg;
  logic [7:0]              cmd_next;
  logic [1:0]              init_cnt_reg;
  logic [1:0]              init_cnt_next;
  logic [7:0]              conv_next;
  logic                    conv_strobe_next;
  logic [7:0]              setup_next;
  logic [7:0]              unipolar_next;
  logic [7:0]              bipolar_next;
  logic [7:0]              avg_next;
  logic [7:0]              rstc_next;
  logic                    reset_strobe_next;
  logic [7:0]              dac_sel_next;
  logic [11:0]             dac_in_next;
  logic                    dac_strobe_next;
  logic [7:0]              gpio_out_next;
  logic                    gpio_cfg_next;
  logic                    gpio_rd_next;
  logic                    eoc_n_next;

  // pins pass two flops before any use
  scd_sync #(
    .W       (5),
    .RST_VAL (5'h1f)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({sclk, cs_n, din, convert_start_n, dac_wake_select}),
    .q     (pins_s)
  );

  assign {sclk_s, cs_s, din_s, cnv_s, wake_s} = pins_s;

  // edge detection on synchronised levels, either idle level works
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_reg <= 1'b1;
      cs_d_reg   <= 1'b1;
      cnv_d_reg  <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
      cs_d_reg   <= cs_s;
      cnv_d_reg  <= cnv_s;
    end
  end

  assign sclk_fall = sclk_d_reg & ~sclk_s;
  assign sclk_rise = ~sclk_d_reg & sclk_s;
  assign cs_fall   = cs_d_reg & ~cs_s;
  assign cnv_fall  = cnv_d_reg & ~cnv_s;
  assign accept    = ~cs_s & sclk_fall & (state_reg != scd_pkg::SCD_IGNORE);
  assign cnt_inc   = bit_cnt_reg + 5'h01;
  assign cmd_byte  = {shift_reg[6:0], din_s};
  assign cmd_done  = accept & (cnt_inc == scd_pkg::LEN_8);
  assign clk_mode  = converter_setup_reg[scd_pkg::SET_CLK_HI:scd_pkg::SET_CLK_LO];

  // receive state, command decode and register updates
  always_comb begin
    state_next        = state_reg;
    bit_cnt_next      = bit_cnt_reg;
    len_next          = len_reg;
    shift_next        = shift_reg;
    cmd_next          = cmd_reg;
    init_cnt_next     = init_cnt_reg;
    conv_next         = conversion_request_reg;
    conv_strobe_next  = 1'b0;
    setup_next        = converter_setup_reg;
    unipolar_next     = unipolar_reg;
    bipolar_next      = bipolar_reg;
    avg_next          = averaging_control_reg;
    rstc_next         = reset_control_reg;
    reset_strobe_next = 1'b0;
    dac_sel_next      = dac_select_reg;
    dac_in_next       = dac_input_reg;
    dac_strobe_next   = 1'b0;
    gpio_out_next     = gpio_out_reg;
    gpio_cfg_next     = 1'b0;
    gpio_rd_next      = 1'b0;
    // strap caught once, after the synchroniser has filled
    if (init_cnt_reg != 2'h3) begin
      init_cnt_next = init_cnt_reg + 2'h1;
    end
    if (init_cnt_reg == scd_pkg::STRAP_LOAD) begin
      dac_in_next = wake_s ? scd_pkg::DAC_WAKE_HI : scd_pkg::DAC_WAKE_LO;
    end
    if (cs_s) begin
      state_next   = scd_pkg::SCD_IDLE;
      bit_cnt_next = 5'h00;
      len_next     = scd_pkg::LEN_8;
    end else if (accept) begin
      state_next   = scd_pkg::SCD_RECV;
      shift_next   = {shift_reg[22:0], din_s};
      bit_cnt_next = cnt_inc;
      if (cmd_done) begin
        cmd_next = cmd_byte;
        len_next = scd_pkg::LEN_8;
        if (cmd_byte[7]) begin
          conv_next        = cmd_byte;
          conv_strobe_next = 1'b1;
        end else if (cmd_byte[6]) begin
          setup_next = cmd_byte;
          if (cmd_byte[scd_pkg::SET_POL_HI]) begin
            len_next = scd_pkg::LEN_16;
          end
        end else if (cmd_byte[5]) begin
          avg_next = cmd_byte;
        end else if (cmd_byte[4]) begin
          len_next = scd_pkg::LEN_24;
        end else if (cmd_byte[3]) begin
          rstc_next         = cmd_byte;
          reset_strobe_next = cmd_byte[scd_pkg::RST_REQ_BIT];
        end else if (HAS_GPIO) begin
          // without gpio these codes fall through untouched
          case (cmd_byte)
            scd_pkg::CMD_GPIO_CFG: gpio_cfg_next = 1'b1;
            scd_pkg::CMD_GPIO_WR:  len_next = scd_pkg::LEN_16;
            scd_pkg::CMD_GPIO_RD:  gpio_rd_next = 1'b1;
            default:               gpio_cfg_next = 1'b0;
          endcase
        end
        if (len_next == scd_pkg::LEN_8) begin
          state_next = scd_pkg::SCD_IGNORE;
        end
      end else if (cnt_inc == len_reg) begin
        state_next = scd_pkg::SCD_IGNORE;
        if (cmd_reg[7:4] == 4'h1) begin
          dac_sel_next    = shift_reg[14:7];
          dac_in_next     = shift_next[11:0];  // low nibble of byte1, then byte2
          dac_strobe_next = 1'b1;
        end else if (cmd_reg[7:6] == 2'h1) begin
          if (cmd_reg[scd_pkg::SET_POL_HI:scd_pkg::SET_POL_LO] == scd_pkg::POL_BIPOLAR) begin
            bipolar_next = shift_next[7:0];
          end else begin
            unipolar_next = shift_next[7:0];
          end
        end else begin
          gpio_out_next = shift_next[7:0];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg              <= scd_pkg::SCD_IDLE;
      bit_cnt_reg            <= 5'h00;
      len_reg                <= scd_pkg::LEN_8;
      shift_reg              <= 24'h000000;
      cmd_reg                <= scd_pkg::ZERO_RST;
      init_cnt_reg           <= 2'h0;
      conversion_request_reg <= scd_pkg::ZERO_RST;
      conv_strobe_reg        <= 1'b0;
      converter_setup_reg    <= scd_pkg::SETUP_RST;
      unipolar_reg           <= scd_pkg::ZERO_RST;
      bipolar_reg            <= scd_pkg::ZERO_RST;
      averaging_control_reg  <= scd_pkg::ZERO_RST;
      reset_control_reg      <= scd_pkg::ZERO_RST;
      reset_strobe_reg       <= 1'b0;
      dac_select_reg         <= scd_pkg::ZERO_RST;
      dac_input_reg          <= scd_pkg::DAC_WAKE_LO;
      dac_strobe_reg         <= 1'b0;
      gpio_out_reg           <= scd_pkg::ZERO_RST;
      gpio_cfg_strobe_reg    <= 1'b0;
      gpio_read_strobe_reg   <= 1'b0;
    end else begin
      state_reg              <= state_next;
      bit_cnt_reg            <= bit_cnt_next;
      len_reg                <= len_next;
      shift_reg              <= shift_next;
      cmd_reg                <= cmd_next;
      init_cnt_reg           <= init_cnt_next;
      conversion_request_reg <= conv_next;
      conv_strobe_reg        <= conv_strobe_next;
      converter_setup_reg    <= setup_next;
      unipolar_reg           <= unipolar_next;
      bipolar_reg            <= bipolar_next;
      averaging_control_reg  <= avg_next;
      reset_control_reg      <= rstc_next;
      reset_strobe_reg       <= reset_strobe_next;
      dac_select_reg         <= dac_sel_next;
      dac_input_reg          <= dac_in_next;
      dac_strobe_reg         <= dac_strobe_next;
      gpio_out_reg           <= gpio_out_next;
      gpio_cfg_strobe_reg    <= gpio_cfg_next;
      gpio_read_strobe_reg   <= gpio_rd_next;
    end
  end

  // result formatting: offset code flipped to two's complement when signed
  assign res_fmt   = result_signed ? {~result_code[9], result_code[8:0]} : result_code;
  assign out_shift = ~cs_s & ((clk_mode == scd_pkg::CLK_MODE_EXT) ? sclk_rise
                                                                   : sclk_fall);

  scd_out_shift #(
    .W (scd_pkg::OUT_BITS)
  ) u_out (
    .clk       (clk),
    .rst_n     (rst_n),
    .load      (cs_fall),
    .load_word ({scd_pkg::OUT_LEAD, res_fmt, scd_pkg::OUT_TAIL}),
    .shift     (out_shift),
    .msb       (out_msb)
  );

  // pin-facing outputs, end of conversion and convert start role
  always_comb begin
    eoc_n_next = eoc_n_reg;
    if (clk_mode == scd_pkg::CLK_MODE_EXT) begin
      eoc_n_next = 1'b1;
    end else if (cs_fall | cnv_fall) begin
      eoc_n_next = 1'b1;
    end else if (op_done) begin
      eoc_n_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout_reg           <= 1'b0;
      dout_oe_reg        <= 1'b0;
      eoc_n_reg          <= 1'b1;
      conv_start_reg     <= 1'b0;
      convert_start_n_is_start_reg <= 1'b0;
    end else begin
      dout_reg           <= out_msb;
      dout_oe_reg        <= ~cs_s;
      eoc_n_reg          <= eoc_n_next;
      conv_start_reg     <= cnv_fall & convert_start_n_is_start_reg;
      convert_start_n_is_start_reg <= (clk_mode == scd_pkg::CLK_MODE_INT_CNV)
                          | (clk_mode == scd_pkg::CLK_MODE_EXT_CNV);
    end
  end

  sequence gpio_wr_cmd_s;
    cmd_done && (cmd_byte == scd_pkg::CMD_GPIO_WR);
  endsequence

  sequence data_byte_s;
    (state_reg == scd_pkg::SCD_RECV) && accept && (cnt_inc == scd_pkg::LEN_16);
  endsequence

  idle_return_a: assert property (@(posedge clk) disable iff (!rst_n)
    cs_s |=> (state_reg == scd_pkg::SCD_IDLE) && (bit_cnt_reg == 5'h00))
    else $error("port not idle after chip select high");

  din_sample_a: assert property (@(posedge clk) disable iff (!rst_n)
    accept |=> (shift_reg[0] == $past(din_s)))
    else $error("serial input not sampled on falling edge");

  conv_decode_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cmd_done && cmd_byte[7]) |=> conv_strobe_reg
      && (conversion_request_reg == $past(cmd_byte)))
    else $error("conversion command not decoded");

  setup_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    (init_cnt_reg == 2'h0) |-> (converter_setup_reg == scd_pkg::SETUP_RST))
    else $error("setup register reset value wrong");

  dac_wake_a: assert property (@(posedge clk) disable iff (!rst_n)
    (init_cnt_reg == scd_pkg::STRAP_LOAD) |=> (dac_input_reg ==
      ($past(wake_s) ? scd_pkg::DAC_WAKE_HI : scd_pkg::DAC_WAKE_LO)))
    else $error("dac input power-up value wrong");

  eoc_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_mode == scd_pkg::CLK_MODE_EXT) |=> eoc_n_reg)
    else $error("end of conversion low in external clock mode");

  ignore_extra_a: assert property (@(posedge clk) disable iff (!rst_n)
    ((state_reg == scd_pkg::SCD_IGNORE) && !cs_s) |=> $stable(gpio_out_reg)
      && $stable(unipolar_reg) && $stable(bipolar_reg) && !dac_strobe_reg)
    else $error("bits past transaction length changed state");

  gpio_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    gpio_wr_cmd_s |=> !HAS_GPIO || (len_reg == scd_pkg::LEN_16))
    else $error("gpio write length wrong");

  gpio_data_a: assert property (@(posedge clk) disable iff (!rst_n)
    (data_byte_s and (cmd_reg == scd_pkg::CMD_GPIO_WR) and (HAS_GPIO == 1'b1))
      |=> (gpio_out_reg == $past(shift_next[7:0]))
        && (state_reg == scd_pkg::SCD_IGNORE))
    else $error("gpio data byte not applied");

endmodule

// [scd_spi_master.sv]
// bus master model for the serial port: frames of up to 24 bits, msb first
// assumes the caller starts a frame only while chip select is high
`timescale 1ns/1ps
module scd_spi_master (
  input  wire logic dout,
  input  wire logic dout_oe,
  output logic      sclk,
  output logic      cs_n,
  output logic      din
);
  logic [23:0] rx;
  logic        oe_all;
  logic        smp_level;

  // idle levels at time zero: deselected, clock low
  initial begin
    sclk      = 1'b0;
    cs_n      = 1'b1;
    din       = 1'b1;
    rx        = 24'h000000;
    oe_all    = 1'b0;
    smp_level = 1'b1;
  end

  // clock level after the edge on which serial output is read
  task automatic set_sample(input logic lvl);
    smp_level = lvl;
  endtask

  // read serial output and its enable on the chosen edge
  task automatic take();
    if (sclk == smp_level) begin
      rx     = {rx[22:0], dout};
      oe_all = oe_all & dout_oe;
    end
  endtask

  // clock idles at the chosen level between frames
  task automatic set_idle(input logic hi);
    sclk = hi;
  endtask

  // one frame: nbits taken from bit 23 downwards
  task automatic xfer(input logic [23:0] data, input int nbits);
    rx = 24'h000000;
    oe_all = 1'b1;
    cs_n = 1'b0;
    #40;
    for (int i = 23; i > 23 - nbits; i--) begin
      din = data[i];
      #20 sclk = ~sclk;
      take();
      #40 sclk = ~sclk;
      take();
      #20;
    end
    #40 cs_n = 1'b1;
    din = ~din; // released line shows no stale value
  endtask
endmodule

// [tb_serial_command_decoder.sv]
// self-checking bench for the serial command decoder
// assumes the design package is compiled first; master model drives the serial pins
`timescale 1ns/1ps
module tb_serial_command_decoder;
  logic clk, rst_n, sclk, cs_n, din, cnv_n, op_done, wake, res_signed;
  logic dout, dout_oe, eoc_n, conv_start, cnv_is_start, conv_stb, rst_stb, dac_stb;
  logic gcfg_stb, grd_stb;
  logic [7:0]  conv_req, setup, unip, bip, avg, rst_ctl, dac_sel, gpio_out;
  logic [11:0] dac_in;
  int fail_count, compares, n_conv, n_rst, n_dac, n_cfg, n_rd, n_cs;

  scd_spi_master u_scd_spi_master (.dout(dout), .dout_oe(dout_oe), .sclk(sclk),
    .cs_n(cs_n), .din(din));

  scd_serial_decoder u_scd_serial_decoder (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
    .convert_start_n(cnv_n), .dac_wake_select(wake), .op_done(op_done),
    .result_signed(res_signed), .result_code(10'h2a5), .dout_reg(dout),
    .dout_oe_reg(dout_oe), .eoc_n_reg(eoc_n), .conv_start_reg(conv_start),
    .convert_start_n_is_start_reg(cnv_is_start), .conversion_request_reg(conv_req),
    .conv_strobe_reg(conv_stb), .converter_setup_reg(setup), .unipolar_reg(unip),
    .bipolar_reg(bip), .averaging_control_reg(avg), .reset_control_reg(rst_ctl),
    .reset_strobe_reg(rst_stb), .dac_select_reg(dac_sel), .dac_input_reg(dac_in),
    .dac_strobe_reg(dac_stb), .gpio_out_reg(gpio_out),
    .gpio_cfg_strobe_reg(gcfg_stb), .gpio_read_strobe_reg(grd_stb)
  );

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // count one-cycle strobes so that none is missed
  always @(posedge clk) begin
    n_conv <= n_conv + int'(conv_stb === 1'b1);
    n_rst  <= n_rst + int'(rst_stb === 1'b1);
    n_dac  <= n_dac + int'(dac_stb === 1'b1);
    n_cfg  <= n_cfg + int'(gcfg_stb === 1'b1);
    n_rd   <= n_rd + int'(grd_stb === 1'b1);
    n_cs   <= n_cs + int'(conv_start === 1'b1);
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // one frame then time for the synchronised effects to land
  task automatic frame(input logic [23:0] data, input int nbits);
    @(posedge clk) #1;
    u_scd_serial_decoder_frame_call(data, nbits);
    repeat (10) @(posedge clk);
    #1;
  endtask

  task automatic u_scd_serial_decoder_frame_call(input logic [23:0] d, input int n);
    u_scd_spi_master.xfer(d, n);
  endtask

  task automatic test_reset();
    check(24'(setup), 24'h28);
    check({unip, bip, avg}, 24'h0);
    check({rst_ctl, conv_req, dac_sel}, 24'h0);
    check(24'({gpio_out, dout_oe}), 24'h0);
    check(24'(dac_in), 24'hfff);
    check(24'(eoc_n), 24'h1);
    $display("done: reset values");
  endtask

  task automatic test_conv_setup();
    frame(24'hb50000, 8);
    check(24'(conv_req), 24'hb5);
    check(24'(n_conv), 24'h1);
    frame(24'h400000, 8);
    check(24'(setup), 24'h40);
    check(24'(cnv_is_start), 24'h1);
    frame(24'h625a00, 16);
    check(24'({setup, unip}), 24'h625a);
    check(24'(cnv_is_start), 24'h0);
    check(u_scd_spi_master.rx, 24'h000a94);
    check(24'(u_scd_spi_master.oe_all), 24'h1);
    res_signed = 1'b1;
    frame(24'h63a500, 16);
    check(24'(bip), 24'ha5);
    check(u_scd_spi_master.rx, 24'h000294);
    u_scd_spi_master.set_sample(1'b0);
    frame(24'h700000, 8);
    frame(24'h000000, 16);
    check(u_scd_spi_master.rx, 24'h000528);
    check(24'(setup), 24'h70);
    u_scd_spi_master.set_sample(1'b1);
    $display("done: conversion and setup");
  endtask

  task automatic test_avg_dac_reset();
    u_scd_spi_master.set_idle(1'b1);
    frame(24'h3b0000, 8);
    check(24'(avg), 24'h3b);
    u_scd_spi_master.set_idle(1'b0);
    frame(24'h1f37c4, 24);
    check(24'({dac_sel, dac_in}), {8'h37, 12'h7c4});
    check(24'(n_dac), 24'h1);
    frame(24'h0c0000, 8);
    check(24'(rst_ctl), 24'h0c);
    check(24'(n_rst), 24'h1);
    $display("done: averaging, dac, reset");
  endtask

  task automatic test_gpio();
    frame(24'h029600, 16);
    check(24'(gpio_out), 24'h96);
    frame(24'h030000, 8);
    frame(24'h010000, 8);
    frame(24'h000000, 8);
    check(24'({n_cfg[3:0], n_rd[3:0], n_conv[3:0]}), 24'h111);
    $display("done: gpio");
  endtask

  task automatic test_abort_extra();
    frame(24'h1a5500, 12);
    check(24'({dac_sel, dac_in}), {8'h37, 12'h7c4});
    check(24'(n_dac), 24'h1);
    frame(24'h810c5a, 24);
    check(24'(conv_req), 24'h81);
    check(24'(n_rst), 24'h1);
    $display("done: abort and extra bits");
  endtask

  task automatic test_eoc();
    frame(24'h400000, 8);
    @(posedge clk) #1 op_done = 1'b1;
    @(posedge clk) #1 op_done = 1'b0;
    repeat (3) @(posedge clk);
    #1 check(24'(eoc_n), 24'h0);
    cnv_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 cnv_n = 1'b1;
    repeat (6) @(posedge clk);
    #1 check(24'(eoc_n), 24'h1);
    check(24'(n_cs), 24'h1);
    $display("done: end of conversion");
  endtask

  // second reset in mid-run with the wake strap low
  task automatic test_wake_low();
    wake = 1'b0;
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (10) @(posedge clk);
    #1 check(24'(dac_in), 24'h000);
    check(24'({setup, avg}), 24'h2800);
    $display("done: reset with wake select low");
  endtask

  // watchdog: tests need about 19 us
  initial begin
    #200000;
    fail_count++;
    stop_test();
  end

  initial begin
    rst_n = 1'b0;
    cnv_n = 1'b1;
    op_done = 1'b0;
    wake = 1'b1;
    res_signed = 1'b0;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    test_reset();
    test_conv_setup();
    test_avg_dac_reset();
    test_gpio();
    test_abort_extra();
    test_eoc();
    test_wake_low();
    stop_test();
  end
endmodule
